// *** rtl/dual_slope_defines.svh ***
`ifndef DUAL_SLOPE_DEFINES_SVH
`define DUAL_SLOPE_DEFINES_SVH
// Phase lengths in counts (one count is two clock cycles)
`define ZERO_BASE_COUNTS 13'd500
`define AUTO_ZERO_COUNTS 13'd1500
`define INTEGRATE_COUNTS 13'd2000
`define DEINT_MAX_COUNTS 13'd4001
// Width of the end-of-conversion low pulse in clock cycles
`define EOC_PULSE_CYCLES 4'h4
// Reset value of the display register
`define DISPLAY_RESET 13'h0000
`endif

// *** rtl/dual_slope_pkg.sv ***
package dual_slope_pkg;
    // Conversion phases, one-hot
    typedef enum logic [3:0] {
        PH_ZERO = 4'b0001,
        PH_AUTO_ZERO = 4'b0010,
        PH_INTEGRATE = 4'b0100,
        PH_DEINT = 4'b1000
    } phase_t;
    // Width of count values
    typedef logic [12:0] count_t;
endpackage : dual_slope_pkg

// *** rtl/sync2.sv ***
`timescale 1ns/10ps
// Two flip-flop synchroniser for one pin level
module sync2 (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic async_in,
    output logic sync_out
);
    logic meta; // First stage, read only by the second
    // Shift the pin level through two stages
    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta <= 1'b0;
            sync_out <= 1'b0;
        end else if (ce) begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : sync2

// *** rtl/dual_slope_conversion_sequencer.sv ***
`timescale 1ns/10ps
`include "dual_slope_defines.svh"
// Behaviour
// - Pulse end-of-conversion pin low after each conversion
// - Pin held high freezes display, conversions continue
// - Integrate input for fixed count from zero
// - Apply opposite reference until comparator crosses zero or deintegrate count limit is reached
// - Deintegration count is the conversion result
// - Zero-output then auto-zero before each integration
// - Phase counters advance once every two clocks
// - Auto-zero lasts fixed count
// - Signal integration lasts fixed count
// - Zero phase is base plus unused deintegrate counts
module dual_slope_conversion_sequencer (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ce,
    input wire logic comp_in, // Comparator: integrator output positive
    input wire logic eoc_in, // Level seen on the end-of-conversion pin
    output logic eoc_out, // Level driven on the pin
    output logic eoc_oe, // High while the pin is driven
    output logic sw_zero, // Zero-integrator-output switches
    output logic sw_auto_zero, // Auto-zero switches
    output logic sw_input, // Input connected to integrator
    output logic sw_ref_pos, // Positive reference connected
    output logic sw_ref_neg, // Negative reference connected
    output dual_slope_pkg::count_t display_value, // Displayed magnitude
    output logic display_negative, // Displayed sign
    output logic overrange // Displayed reading ran out of counts
);
    import dual_slope_pkg::*;

    // ****************************************
    // Pin and comparator synchronisation
    // ****************************************
    logic comp_s; // Synchronised comparator
    logic hold_s; // Synchronised pin level
    sync2 u_sync_comp (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .async_in(comp_in),
        .sync_out(comp_s)
    );
    sync2 u_sync_hold (
        .clock(clock),
        .rstn(rstn),
        .ce(ce),
        .async_in(eoc_in),
        .sync_out(hold_s)
    );

    // ****************************************
    // Count enable and phase decode
    // ****************************************
    logic half; // Divide-by-two toggle
    phase_t phase; // Current phase
    count_t cnt; // Count inside the phase
    count_t zero_len; // Length of the coming zero phase
    logic sign_neg; // Polarity latched at end of integration
    logic [3:0] pulse_cnt; // Remaining low-pulse cycles
    count_t pend_value; // Reading waiting for the end of the pulse
    logic pend_neg; // Sign waiting for the end of the pulse
    logic pend_over; // Overrange waiting for the end of the pulse
    wire tick = ce && half; // One count every two clocks
    wire last_zero = (phase == PH_ZERO) && (cnt == zero_len - 13'd1);
    wire last_az = (phase == PH_AUTO_ZERO) && (cnt == `AUTO_ZERO_COUNTS - 13'd1);
    wire last_int = (phase == PH_INTEGRATE) && (cnt == `INTEGRATE_COUNTS - 13'd1);
    // Zero crossing: comparator flips away from the integrated polarity
    wire crossed = (phase == PH_DEINT) && (comp_s == sign_neg);
    wire deint_full = (phase == PH_DEINT) && (cnt == `DEINT_MAX_COUNTS - 13'd1);
    wire end_deint = (phase == PH_DEINT) && (crossed || deint_full);
    wire [12:0] result = crossed ? cnt : cnt + 13'd1; // Counts used
    // Counts spent in deintegration, the ending count included
    wire [12:0] spent = cnt + 13'd1;
    // Pad with what deintegration left unused, so every cycle has one length
    wire [12:0] next_zero_len = `ZERO_BASE_COUNTS + (`DEINT_MAX_COUNTS - spent);
    wire pulse_last = (pulse_cnt == 4'h1); // Final cycle of the low pulse
    // Pin still high at the end of our own low pulse: an outside party holds it
    wire display_hold = pulse_last && hold_s;
    wire display_load = ce && pulse_last && !hold_s; // Pin followed our drive

    // Divide the clock by two
    always_ff @(posedge clock) begin
        if (!rstn) half <= 1'b0;
        else if (ce) half <= ~half;
    end

    // ****************************************
    // Phase sequencer
    // ****************************************
    // Advance phases and count within them
    always_ff @(posedge clock) begin
        if (!rstn) begin
            phase <= PH_ZERO;
            cnt <= 13'h0000;
            zero_len <= `ZERO_BASE_COUNTS;
            sign_neg <= 1'b0;
        end else if (tick) begin
            case (phase)
                PH_ZERO: begin
                    // Discharge integrator first
                    cnt <= last_zero ? 13'h0000 : cnt + 13'd1;
                    if (last_zero) phase <= PH_AUTO_ZERO;
                end
                PH_AUTO_ZERO: begin
                    cnt <= last_az ? 13'h0000 : cnt + 13'd1;
                    if (last_az) phase <= PH_INTEGRATE;
                end
                PH_INTEGRATE: begin
                    cnt <= last_int ? 13'h0000 : cnt + 13'd1;
                    if (last_int) begin
                        phase <= PH_DEINT;
                        sign_neg <= ~comp_s; // Polarity at end of integration
                    end
                end
                PH_DEINT: begin
                    // Run until zero crossing or count limit
                    cnt <= end_deint ? 13'h0000 : cnt + 13'd1;
                    if (end_deint) begin
                        phase <= PH_ZERO;
                        zero_len <= next_zero_len;
                    end
                end
                default: begin
                    phase <= PH_ZERO;
                    cnt <= 13'h0000;
                end
            endcase
        end
    end

    // ****************************************
    // Switch outputs
    // ****************************************
    // Register analog switch controls from the phase
    always_ff @(posedge clock) begin
        if (!rstn) begin
            sw_zero <= 1'b1;
            sw_auto_zero <= 1'b0;
            sw_input <= 1'b0;
            sw_ref_pos <= 1'b0;
            sw_ref_neg <= 1'b0;
        end else if (ce) begin
            sw_zero <= (phase == PH_ZERO);
            sw_auto_zero <= (phase == PH_AUTO_ZERO);
            sw_input <= (phase == PH_INTEGRATE);
            sw_ref_pos <= (phase == PH_DEINT) && sign_neg;
            sw_ref_neg <= (phase == PH_DEINT) && !sign_neg;
        end
    end

    // ****************************************
    // Result and end-of-conversion pulse
    // ****************************************
    // Capture the reading at the end of deintegration
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pend_value <= `DISPLAY_RESET;
            pend_neg <= 1'b0;
            pend_over <= 1'b0;
        end else if (tick && end_deint) begin
            pend_value <= result;
            pend_neg <= sign_neg;
            pend_over <= deint_full && !crossed;
        end
    end

    // Load the display as the pulse ends, unless the pin stayed high
    always_ff @(posedge clock) begin
        if (!rstn) begin
            display_value <= `DISPLAY_RESET;
            display_negative <= 1'b0;
            overrange <= 1'b0;
        end else if (display_load) begin
            display_value <= pend_value;
            display_negative <= pend_neg;
            overrange <= pend_over;
        end
    end

    // Drive a short low pulse on the pin, then release it to its pull-up
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pulse_cnt <= 4'h0;
            eoc_out <= 1'b1;
            eoc_oe <= 1'b0;
        end else if (ce) begin
            if (tick && end_deint) pulse_cnt <= `EOC_PULSE_CYCLES;
            else if (pulse_cnt != 4'h0) pulse_cnt <= pulse_cnt - 4'h1;
            eoc_out <= 1'b0;
            eoc_oe <= (tick && end_deint) || (pulse_cnt > 4'h1);
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    property p_eoc_pulse;
        @(posedge clock) disable iff (!rstn)
            (ce && tick && end_deint) |=> (eoc_oe && !eoc_out);
    endproperty
    a_eoc_pulse: assert property (p_eoc_pulse) else $error("No low pulse at end");

    property p_release;
        @(posedge clock) disable iff (!rstn)
            (ce && pulse_last) |=> !eoc_oe;
    endproperty
    a_release: assert property (p_release) else $error("Pin not released");

    property p_hold;
        @(posedge clock) disable iff (!rstn)
            (ce && display_hold) |=> $stable(display_value);
    endproperty
    a_hold: assert property (p_hold) else $error("Display changed while held");

    property p_int_len;
        @(posedge clock) disable iff (!rstn)
            (tick && last_az) |=> (phase == PH_INTEGRATE) && (cnt == 13'h0000);
    endproperty
    a_int_len: assert property (p_int_len) else $error("Integration did not start");

    property p_int_end;
        @(posedge clock) disable iff (!rstn)
            (tick && phase == PH_INTEGRATE && cnt == `INTEGRATE_COUNTS - 13'd1)
                |=> (phase == PH_DEINT);
    endproperty
    a_int_end: assert property (p_int_end) else $error("Integration length wrong");

    property p_ref_opp;
        @(posedge clock) disable iff (!rstn)
            (phase == PH_DEINT && ce) |=> (sw_ref_pos == sign_neg) && (sw_ref_neg == !sign_neg);
    endproperty
    a_ref_opp: assert property (p_ref_opp) else $error("Reference polarity wrong");

    property p_result;
        @(posedge clock) disable iff (!rstn)
            (tick && crossed) |=> (pend_value == $past(cnt));
    endproperty
    a_result: assert property (p_result) else $error("Result not deint count");

    property p_load;
        @(posedge clock) disable iff (!rstn)
            display_load |=> (display_value == $past(pend_value))
                && (display_negative == $past(pend_neg));
    endproperty
    a_load: assert property (p_load) else $error("Display not loaded");

    property p_order;
        @(posedge clock) disable iff (!rstn)
            (tick && last_zero) |=> (phase == PH_AUTO_ZERO);
    endproperty
    a_order: assert property (p_order) else $error("Auto-zero not after zero");

    property p_div;
        @(posedge clock) disable iff (!rstn)
            (ce && !half && phase != PH_DEINT) |=> $stable(cnt);
    endproperty
    a_div: assert property (p_div) else $error("Count moved on odd clock");

    property p_total;
        @(posedge clock) disable iff (!rstn)
            (tick && end_deint)
                |=> (zero_len + $past(spent) == `ZERO_BASE_COUNTS + `DEINT_MAX_COUNTS);
    endproperty
    a_total: assert property (p_total) else $error("Cycle length not constant");
endmodule : dual_slope_conversion_sequencer

// *** tb/integrator_model.sv ***
`timescale 1ns/10ps
// ****************************************
// Integrator, comparator and hold switch
// ****************************************
module integrator_model (
    input wire logic clock,
    input wire logic sw_zero,
    input wire logic sw_auto_zero,
    input wire logic sw_input,
    input wire logic sw_ref_pos,
    input wire logic sw_ref_neg,
    input wire logic eoc_oe,
    input wire logic eoc_out,
    input wire logic hold, // Holder ties the pin high
    input wire logic signed [15:0] vin, // Input in display counts
    output logic comp_in,
    output logic eoc_in
);
    longint integ = 0; // Integrator charge, input ramps vin per clock
    // Charge follows whichever switch the sequencer closes
    always @(posedge clock) begin
        if (sw_zero || sw_auto_zero) begin
            integ <= 0;
        end else if (sw_input) begin
            integ <= integ + vin;
        end else if (sw_ref_neg) begin
            integ <= integ - 2000;
        end else if (sw_ref_pos) begin
            integ <= integ + 2000;
        end
    end
    // Comparator is high while the integrator sits above zero
    assign comp_in = (integ > 0);
    // Pin has a pull-up; a holder tied high overrides the device's low drive
    assign eoc_in = hold ? 1'b1 : (eoc_oe ? eoc_out : 1'b1);
endmodule : integrator_model

// *** tb/dual_slope_conversion_sequencer_tb.sv ***
`timescale 1ns/10ps
// ****************************************
// Bench for the conversion sequencer
// ****************************************
module dual_slope_conversion_sequencer_tb;
    import dual_slope_pkg::*;
    logic clock = 0;
    logic rstn = 0;
    logic hold = 0;
    logic signed [15:0] vin = 16'sh04D2; // 1234 counts
    logic comp_in, eoc_in, eoc_out, eoc_oe, sw_zero, sw_auto_zero;
    logic sw_input, sw_ref_pos, sw_ref_neg, display_negative, overrange;
    count_t display_value;
    int err_count = 0;
    int compares = 0;
    int az_run = 0, az_len = 0, in_run = 0, in_len = 0; // Phase lengths
    int oe_run = 0, oe_len = 0, per = 0, per_len = 0; // Pulse, cycle
    logic az_q = 0;
    always #4 clock = ~clock;
    dual_slope_conversion_sequencer dut (.clock(clock), .rstn(rstn), .ce(1'b1),
        .comp_in(comp_in), .eoc_in(eoc_in), .eoc_out(eoc_out), .eoc_oe(eoc_oe),
        .sw_zero(sw_zero), .sw_auto_zero(sw_auto_zero), .sw_input(sw_input),
        .sw_ref_pos(sw_ref_pos), .sw_ref_neg(sw_ref_neg),
        .display_value(display_value), .display_negative(display_negative),
        .overrange(overrange));
    integrator_model far (.clock(clock), .sw_zero(sw_zero),
        .sw_auto_zero(sw_auto_zero), .sw_input(sw_input), .sw_ref_pos(sw_ref_pos),
        .sw_ref_neg(sw_ref_neg), .eoc_oe(eoc_oe), .eoc_out(eoc_out), .hold(hold),
        .vin(vin), .comp_in(comp_in), .eoc_in(eoc_in));
    // Measure phase runs, pulse width and cycle period (auto-zero to auto-zero)
    always @(posedge clock) begin
        if (sw_auto_zero) az_run++; else if (az_run != 0) begin az_len = az_run; az_run = 0; end
        if (sw_input) in_run++; else if (in_run != 0) begin in_len = in_run; in_run = 0; end
        if (eoc_oe) oe_run++; else if (oe_run != 0) begin oe_len = oe_run; oe_run = 0; end
        per++;
        if (sw_auto_zero === 1'b1 && !az_q) begin
            per_len = per;
            per = 0;
        end
        az_q = sw_auto_zero;
    end
    // Exact comparison
    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Reading within comparator sync slack
    task chk_near(input count_t got, input int exp);
        compares++;
        if (((got >= exp - 3) && (got <= exp + 3)) !== 1'b1) begin
            err_count++;
            $display("BAD %0t reading %0d expected %0d", $time, got, exp);
        end
    endtask : chk_near
    // Run one conversion with the given input and hold level
    task conv(input logic signed [15:0] v, input logic h);
        int n;
        @(posedge clock);
        vin <= v;
        hold <= h;
        n = 0;
        do begin @(posedge clock); #1; n++; end while (eoc_oe !== 1'b1 && n < 25000);
        chk(n < 25000, 1'b1);
        chk(eoc_out, 1'b0);
        @(posedge clock);
        #1;
        chk(eoc_in, h);
        n = 0;
        while (eoc_oe !== 1'b0 && n < 10) begin @(posedge clock); #1; n++; end
        chk(eoc_oe, 1'b0);
        @(posedge clock);
        #1;
        chk(eoc_in, 1'b1);
        chk(oe_len, 4);
    endtask : conv
    // Reset state: zero phase switches only, blank display
    task t_reset;
        chk({sw_zero, sw_auto_zero, sw_input, sw_ref_pos, sw_ref_neg}, 5'b10000);
        chk({eoc_oe, display_negative}, 2'b00);
        chk(display_value, 13'h0000);
    endtask : t_reset
    // Positive then negative readings, phase and cycle lengths
    task t_readings;
        conv(16'sh04D2, 1'b0);
        chk_near(display_value, 1234);
        chk(display_negative, 1'b0);
        conv(-16'sh02BC, 1'b0);
        chk_near(display_value, 700);
        chk(display_negative, 1'b1);
        chk(az_len, 3000);
        chk(in_len, 4000);
        chk(per_len, 16002);
    endtask : t_readings
    // Held pin keeps the display while conversions go on
    task t_hold;
        conv(16'sh012C, 1'b1);
        chk_near(display_value, 700);
        chk(display_negative, 1'b1);
        chk(overrange, 1'b0);
        chk(per_len, 16002);
        chk(in_len, 4000);
    endtask : t_hold
    // Input beyond full scale runs out of deintegration counts
    task t_over;
        conv(16'sh1388, 1'b0);
        chk(overrange, 1'b1);
        chk(display_value, 16'd4001);
        chk(per_len, 16002);
        conv(16'sh1388, 1'b0);
        chk(per_len, 16002);
        chk(display_negative, 1'b0);
    endtask : t_over
    // Verdict and end of run
    task results;
        if (err_count == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results
    // Watchdog over the expected run of about five conversions
    initial begin
        #(8 * 95000);
        err_count++;
        results;
    end
    // Main sequence
    initial begin
        repeat (11) @(posedge clock);
        #1;
        t_reset;
        @(posedge clock);
        rstn <= 1'b1;
        t_readings;
        t_hold;
        t_over;
        results;
    end
endmodule : dual_slope_conversion_sequencer_tb
